// file: mcc_pkg.sv
// package: constants and types for the master clock control block
// Overview of operation
// R1: clearing an enable powers down the input block or digital loop
// R2: loop one source code 0xx means analog-only mode
// R3: source 100 with both enables set gives digital-plus-analog mode
// R4: analog-only mode offers no activity or frequency monitoring; the loop two reference monitor still runs
// R5: select bit 1 feeds oscillator pin clock to block and loop
// R6: select bit 0 feeds divided analog loop two clock instead
// R7: master clock divider divides loop two output by two or three
// R8: software keeps loop two output inside the allowed frequency bands
// R9: loop two output may be routed to any of four output banks
// R10: crystal mode needs both crystal pin enables set
// R11: single-ended crystal input sets input enable, clears output enable
// R12: unused crystal input clears both crystal pin enables
// R13: offset field in mixed mode, feedback divider in analog-only mode
// R14: software sets oscillator input enable before using that input
// R15: divider stays off while its field is zero
// R16: loop two input stopped or off frequency sets latched fail flag
package mcc_pkg;

   // =========================================================
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int MON_WINDOW_NS = 10000;
   localparam int MON_WINDOW_CYC = MON_WINDOW_NS / CLK_PERIOD_NS;

   // =========================================================
   // register map
   localparam logic [3:0] ADDR_CFG_ONE = 4'h0;
   localparam logic [3:0] ADDR_CFG_TWO = 4'h1;
   localparam logic [3:0] ADDR_CFG_THREE = 4'h2;
   localparam logic [3:0] ADDR_LOOP_ONE_SRC = 4'h3;
   localparam logic [3:0] ADDR_LOOP_TWO_SRC = 4'h4;
   localparam logic [3:0] ADDR_FREQ_OFFSET = 4'h5;
   localparam logic [3:0] ADDR_FB_DIV_ONE = 4'h6;
   localparam logic [3:0] ADDR_FB_DIV_TWO = 4'h7;
   localparam logic [3:0] ADDR_BANK_ROUTE = 4'h8;
   localparam logic [3:0] ADDR_MODE_STATUS = 4'h9;
   localparam logic [3:0] ADDR_INT_STATUS = 4'hA;
   localparam logic [3:0] ADDR_INT_MASK = 4'hB;

   // =========================================================
   // field positions
   localparam int CFG1_IB_BIT = 0;
   localparam int CFG1_DL_BIT = 1;
   localparam int CFG2_DIV_LSB = 0;
   localparam int CFG2_OSC_EN_BIT = 2;
   localparam int CFG2_XIN_BIT = 3;
   localparam int CFG2_CRYSTAL_OUT_PIN_BIT = 4;
   localparam int CFG3_SEL_BIT = 0;
   localparam int INT_FAIL_BIT = 0;
   localparam int INT_MODE_BIT = 1;
   localparam int INT_W = 2;

   localparam logic [2:0] SRC_DIGITAL = 3'h4;
   localparam logic [1:0] DIV_OFF = 2'h0;
   localparam logic [1:0] DIV_BY_THREE = 2'h3;

   // =========================================================
   // reset values
   localparam logic [2:0] SRC_RESET = 3'h0;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [INT_W-1:0] INT_RESET = 2'h0;

   typedef struct packed {
      logic input_block_enable;
      logic digital_loop_enable;
      logic master_clock_source_select;
      logic master_osc_input_enable;
      logic crystal_input_pin_enable;
      logic crystal_output_pin_enable;
      logic [1:0] master_clock_divider;
   } mcc_cfg_s;

   localparam mcc_cfg_s CFG_RESET = '0;

   typedef enum logic [1:0] {
      MODE_IDLE = 2'h0,
      MODE_ANALOG = 2'h1,
      MODE_MIXED = 2'h3
   } mcc_mode_e;

endpackage : mcc_pkg

// file: mcc_top.sv
// master clock and top-level mode control of the clock multiplier
`timescale 1ns/1ps
module mcc_top
   import mcc_pkg::*;
#(
   parameter int OFFSET_W = 16,
   parameter int FBDIV_W = 16,
   parameter int MON_MIN_TICKS = 4,
   parameter int MON_MAX_TICKS = 240
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic osc_pin_tick,
   input wire logic loop_two_out_tick,
   input wire logic loop_two_ref_tick,
   output logic input_block_pwr_en,
   output logic digital_loop_pwr_en,
   output logic master_clock_tick,
   output logic analog_only_mode,
   output logic digital_analog_mode,
   output logic monitor_enable,
   output logic crystal_in_pin_en,
   output logic crystal_out_pin_en,
   output logic master_osc_in_en,
   output logic [2:0] loop_one_src,
   output logic [2:0] loop_two_src,
   output logic [OFFSET_W-1:0] loop_offset_comp,
   output logic [FBDIV_W-1:0] fb_div_one,
   output logic [FBDIV_W-1:0] fb_div_two,
   output logic [3:0] bank_route,
   output logic master_clock_fail_flag,
   output logic irq
);

   // =========================================================
   // registers
   mcc_cfg_s cfg;
   logic [OFFSET_W-1:0] freq_offset;
   logic [INT_W-1:0] int_status;
   logic [INT_W-1:0] int_mask;
   logic [INT_W-1:0] int_set;
   logic wr_cfg1;
   logic wr_cfg2;

   assign wr_cfg1 = reg_wr && (reg_addr == ADDR_CFG_ONE);
   assign wr_cfg2 = reg_wr && (reg_addr == ADDR_CFG_TWO);

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg <= CFG_RESET;
      end else begin
         if (wr_cfg1) begin
            cfg.input_block_enable <= reg_wdata[CFG1_IB_BIT];
            cfg.digital_loop_enable <= reg_wdata[CFG1_DL_BIT];
         end
         if (wr_cfg2) begin
            cfg.master_clock_divider <= reg_wdata[CFG2_DIV_LSB +: 2];
            cfg.master_osc_input_enable <= reg_wdata[CFG2_OSC_EN_BIT];
            cfg.crystal_input_pin_enable <= reg_wdata[CFG2_XIN_BIT];
            cfg.crystal_output_pin_enable <= reg_wdata[CFG2_CRYSTAL_OUT_PIN_BIT];
         end
         if (reg_wr && reg_addr == ADDR_CFG_THREE) begin
            cfg.master_clock_source_select <= reg_wdata[CFG3_SEL_BIT];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         loop_one_src <= SRC_RESET;
         loop_two_src <= SRC_RESET;
         bank_route <= BANK_RESET;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_LOOP_ONE_SRC) begin
            loop_one_src <= reg_wdata[2:0];
         end
         if (reg_addr == ADDR_LOOP_TWO_SRC) begin
            loop_two_src <= reg_wdata[2:0];
         end
         if (reg_addr == ADDR_BANK_ROUTE) begin
            bank_route <= reg_wdata[3:0]; // R9
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         freq_offset <= '0;
         fb_div_one <= '0;
         fb_div_two <= '0;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_FREQ_OFFSET) begin
            freq_offset <= reg_wdata[OFFSET_W-1:0];
         end
         if (reg_addr == ADDR_FB_DIV_ONE) begin
            fb_div_one <= reg_wdata[FBDIV_W-1:0];
         end
         if (reg_addr == ADDR_FB_DIV_TWO) begin
            fb_div_two <= reg_wdata[FBDIV_W-1:0];
         end
      end
   end

   // =========================================================
   // power and mode
   // the pin enables are passed through as written: software owns
   // the crystal combinations, the block only carries them out
   assign input_block_pwr_en = cfg.input_block_enable; // R1
   assign digital_loop_pwr_en = cfg.digital_loop_enable; // R1
   assign crystal_in_pin_en = cfg.crystal_input_pin_enable; // R10
   assign crystal_out_pin_en = cfg.crystal_output_pin_enable; // R11
   assign master_osc_in_en = cfg.master_osc_input_enable; // R14

   mcc_mode_e mode;

   always_comb begin
      if (!loop_one_src[2]) begin
         mode = MODE_ANALOG; // R2
      end else if (loop_one_src == SRC_DIGITAL && cfg.input_block_enable
                   && cfg.digital_loop_enable) begin
         mode = MODE_MIXED; // R3
      end else begin
         mode = MODE_IDLE;
      end
   end

   assign analog_only_mode = (mode == MODE_ANALOG);
   assign digital_analog_mode = (mode == MODE_MIXED);
   // monitor_enable needs the input block and the loop running; the loop two reference monitor does not
   assign monitor_enable = digital_analog_mode; // R4
   // offset only reaches the digital loop; analog-only mode trims
   // through the feedback divider registers instead
   assign loop_offset_comp = digital_analog_mode ? freq_offset : '0; // R13

   // =========================================================
   // master clock divider and source mux
   logic [1:0] div_cnt;
   logic [1:0] div_last;
   logic div_pulse;

   // code 3 divides by three, any other non-zero code by two
   assign div_last = (cfg.master_clock_divider == DIV_BY_THREE) ?
                     2'h2 : 2'h1; // R7

   always_ff @(posedge clock) begin
      if (rst) begin
         div_cnt <= 2'h0;
         div_pulse <= 1'b0;
      end else if (cfg.master_clock_divider == DIV_OFF) begin
         div_cnt <= 2'h0; // R15
         div_pulse <= 1'b0;
      end else if (loop_two_out_tick) begin
         div_pulse <= (div_cnt >= div_last);
         div_cnt <= (div_cnt >= div_last) ? 2'h0 : div_cnt + 2'h1; // R7
      end else begin
         div_pulse <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         master_clock_tick <= 1'b0;
      end else if (cfg.master_clock_source_select) begin
         master_clock_tick <= osc_pin_tick
                              && cfg.master_osc_input_enable; // R5
      end else begin
         master_clock_tick <= div_pulse; // R6
      end
   end

   // =========================================================
   // loop two reference monitor
   // window counting catches both a stopped and a runaway reference;
   // a fault shorter than a window may go unseen
   logic [8:0] win_cnt;
   logic [8:0] ref_cnt;
   logic win_end;
   logic mon_bad;

   assign win_end = (win_cnt == 9'(MON_WINDOW_CYC - 1));
   assign mon_bad = win_end && (ref_cnt < 9'(MON_MIN_TICKS)
                                || ref_cnt > 9'(MON_MAX_TICKS));

   always_ff @(posedge clock) begin
      if (rst) begin
         win_cnt <= 9'h000;
         ref_cnt <= 9'h000;
      end else if (win_end) begin
         win_cnt <= 9'h000;
         ref_cnt <= 9'h000;
      end else begin
         win_cnt <= win_cnt + 9'h001;
         ref_cnt <= ref_cnt + 9'(loop_two_ref_tick);
      end
   end

   // =========================================================
   // interrupts
   logic mixed_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         mixed_q <= 1'b0;
      end else begin
         mixed_q <= digital_analog_mode;
      end
   end

   always_comb begin
      int_set = INT_RESET;
      int_set[INT_FAIL_BIT] = mon_bad; // R16
      int_set[INT_MODE_BIT] = mixed_q != digital_analog_mode;
   end

   // a set in the same cycle as its clear wins
   always_ff @(posedge clock) begin
      if (rst) begin
         int_status <= INT_RESET;
      end else if (reg_wr && reg_addr == ADDR_INT_STATUS) begin
         int_status <= (int_status & ~reg_wdata[INT_W-1:0]) | int_set;
      end else begin
         int_status <= int_status | int_set; // R16
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         int_mask <= INT_RESET;
      end else if (reg_wr && reg_addr == ADDR_INT_MASK) begin
         int_mask <= reg_wdata[INT_W-1:0];
      end
   end

   assign master_clock_fail_flag = int_status[INT_FAIL_BIT];
   assign irq = |(int_status & int_mask);

   // =========================================================
   // read port
   always_ff @(posedge clock) begin
      if (rst || !reg_rd) begin
         reg_rdata <= 16'h0000;
      end else begin
         unique case (reg_addr)
            ADDR_CFG_ONE: reg_rdata <= {14'h0000,
               cfg.digital_loop_enable, cfg.input_block_enable};
            ADDR_CFG_TWO: reg_rdata <= {11'h000,
               cfg.crystal_output_pin_enable,
               cfg.crystal_input_pin_enable,
               cfg.master_osc_input_enable,
               cfg.master_clock_divider};
            ADDR_CFG_THREE: reg_rdata <= {15'h0000,
               cfg.master_clock_source_select};
            ADDR_LOOP_ONE_SRC: reg_rdata <= {13'h0000, loop_one_src};
            ADDR_LOOP_TWO_SRC: reg_rdata <= {13'h0000, loop_two_src};
            ADDR_FREQ_OFFSET: reg_rdata <= 16'(freq_offset);
            ADDR_FB_DIV_ONE: reg_rdata <= 16'(fb_div_one);
            ADDR_FB_DIV_TWO: reg_rdata <= 16'(fb_div_two);
            ADDR_BANK_ROUTE: reg_rdata <= {12'h000, bank_route};
            ADDR_MODE_STATUS: reg_rdata <= {13'h0000,
               monitor_enable, 2'(mode)};
            ADDR_INT_STATUS: reg_rdata <= {14'h0000, int_status};
            ADDR_INT_MASK: reg_rdata <= {14'h0000, int_mask};
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // =========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_power_down;
      wr_cfg1 && !reg_wdata[CFG1_IB_BIT] |=> !input_block_pwr_en
         && !digital_analog_mode && !monitor_enable;
   endproperty
   a_power_down: assert property (p_power_down) // R1
      else $error("input block still powered after enable cleared");

   property p_loop_down;
      wr_cfg1 && !reg_wdata[CFG1_DL_BIT] |=> !digital_loop_pwr_en
         && !digital_analog_mode;
   endproperty
   a_loop_down: assert property (p_loop_down) // R1
      else $error("digital loop still powered after enable cleared");

   property p_analog_only;
      !loop_one_src[2] |-> analog_only_mode && !digital_analog_mode
         && !monitor_enable && loop_offset_comp == '0;
   endproperty
   a_analog_only: assert property (p_analog_only) // R2
      else $error("analog-only mode not taken for source 0xx");

   property p_mixed;
      loop_one_src == SRC_DIGITAL && input_block_pwr_en
         && digital_loop_pwr_en |-> digital_analog_mode
         && loop_offset_comp == freq_offset;
   endproperty
   a_mixed: assert property (p_mixed) // R3
      else $error("mixed mode not taken with both enables set");

   property p_osc_path;
      cfg.master_clock_source_select && osc_pin_tick
         && master_osc_in_en |=> master_clock_tick;
   endproperty
   a_osc_path: assert property (p_osc_path) // R5
      else $error("oscillator tick not passed as master clock");

   property p_div_path;
      !cfg.master_clock_source_select && div_pulse
         |=> master_clock_tick;
   endproperty
   a_div_path: assert property (p_div_path) // R6
      else $error("divided tick not passed as master clock");

   property p_div_ratio;
      !cfg.master_clock_source_select && master_clock_tick
         && $stable(cfg) |=> !master_clock_tick;
   endproperty
   a_div_ratio: assert property (p_div_ratio) // R7
      else $error("divided master clock ticks back to back");

   property p_div_off;
      cfg.master_clock_divider == DIV_OFF
         && !cfg.master_clock_source_select
         |=> ##1 !master_clock_tick || cfg.master_clock_source_select
         || cfg.master_clock_divider != DIV_OFF;
   endproperty
   a_div_off: assert property (p_div_off) // R15
      else $error("master clock ticks while divider field is zero");

   property p_fail_set;
      mon_bad |=> master_clock_fail_flag;
   endproperty
   a_fail_set: assert property (p_fail_set) // R16
      else $error("fail flag not latched after bad window");

   property p_fail_hold;
      master_clock_fail_flag && !(reg_wr && reg_addr == ADDR_INT_STATUS
         && reg_wdata[INT_FAIL_BIT]) |=> master_clock_fail_flag;
   endproperty
   a_fail_hold: assert property (p_fail_hold) // R16
      else $error("fail flag dropped without a clear");

endmodule : mcc_top

// file: mcc_osc_model.sv
// partner model: oscillator pin, loop two output and loop two input ticks
`timescale 1ns/1ps
module mcc_osc_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic osc_run,
   input wire logic loop_run,
   input wire logic [7:0] ref_period,
   output logic osc_pin_tick,
   output logic loop_two_out_tick,
   output logic loop_two_ref_tick,
   output logic [15:0] osc_count,
   output logic [15:0] loop_count
);
   logic [7:0] ref_cnt;

   // ==========================================================
   // oscillator pin: every other cycle, so edges never merge
   always_ff @(posedge clock) begin
      if (rst) begin
         osc_pin_tick <= 1'b0;
         osc_count <= 16'h0000;
      end else begin
         osc_pin_tick <= osc_run & ~osc_pin_tick;
         if (osc_run & ~osc_pin_tick) begin
            osc_count <= osc_count + 16'h0001;
         end
      end
   end

   // ==========================================================
   // loop two output: self-oscillating, one tick per cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         loop_two_out_tick <= 1'b0;
         loop_count <= 16'h0000;
      end else begin
         loop_two_out_tick <= loop_run;
         if (loop_run) begin
            loop_count <= loop_count + 16'h0001;
         end
      end
   end

   // ==========================================================
   // loop two input: period zero means a dead reference
   always_ff @(posedge clock) begin
      if (rst || ref_period == 8'h00) begin
         ref_cnt <= 8'h00;
         loop_two_ref_tick <= 1'b0;
      end else begin
         loop_two_ref_tick <= (ref_cnt == ref_period - 8'h01);
         ref_cnt <= (ref_cnt == ref_period - 8'h01) ? 8'h00 : ref_cnt + 8'h01;
      end
   end
endmodule : mcc_osc_model

// file: mcc_top_bench.sv
// self-checking bench for the master clock control block
`timescale 1ns/1ps
module mcc_top_bench;
   import mcc_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic osc_run = 1'b0, loop_run = 1'b0;
   logic [7:0] ref_period = 8'h0A;
   logic osc_t, lout_t, lref_t;
   logic [15:0] osc_count, loop_count, rd, mck, base;
   logic ib_en, dl_en, mck_t, ana, mix, mon, crystal_in_pin, crystal_out_pin, oen, fail, irq;
   logic [2:0] src1, src2;
   logic [15:0] offs, fb1, fb2;
   logic [3:0] bank;
   int failures = 0, total_checks = 0, cycles = 0;
   localparam logic [3:0] ADDR_UNMAPPED = 4'hC;

   always #20 clock = ~clock;

   mcc_osc_model i_mcc_osc_model (.clock(clock), .rst(rst),
      .osc_run(osc_run), .loop_run(loop_run), .ref_period(ref_period),
      .osc_pin_tick(osc_t), .loop_two_out_tick(lout_t),
      .loop_two_ref_tick(lref_t), .osc_count(osc_count),
      .loop_count(loop_count));

   mcc_top i_mcc_top (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .osc_pin_tick(osc_t),
      .loop_two_out_tick(lout_t), .loop_two_ref_tick(lref_t),
      .input_block_pwr_en(ib_en), .digital_loop_pwr_en(dl_en),
      .master_clock_tick(mck_t), .analog_only_mode(ana),
      .digital_analog_mode(mix), .monitor_enable(mon),
      .crystal_in_pin_en(crystal_in_pin), .crystal_out_pin_en(crystal_out_pin),
      .master_osc_in_en(oen), .loop_one_src(src1), .loop_two_src(src2),
      .loop_offset_comp(offs), .fb_div_one(fb1), .fb_div_two(fb2),
      .bank_route(bank), .master_clock_fail_flag(fail), .irq(irq));

   // ==========================================================
   // master clock tick counter and hang guard
   always @(posedge clock) begin
      mck <= rst ? 16'h0000 : mck + {15'h0000, mck_t === 1'b1};
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         print_verdict();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic do_reset();
      @(posedge clock);
      rst <= 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
   endtask : do_reset

   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rdreg(logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rdreg

   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // scenarios
   task automatic t_reset_values();
      for (int a = 0; a < 13; a++) begin
         rdreg(a[3:0], rd);
         chk("reset reg", rd, (a == 9) ? 16'h0001 : 16'h0000);
      end
      chk("reset pwr", {ib_en, dl_en, ana, irq}, 16'h0002);
   endtask : t_reset_values

   task automatic t_modes();
      wr(ADDR_FREQ_OFFSET, 16'h1234);
      wr(ADDR_FB_DIV_ONE, 16'hABCD);
      wr(ADDR_CFG_ONE, 16'h0003);
      #1 chk("pwr on", {ib_en, dl_en}, 16'h0003);
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_LOOP_ONE_SRC, s[15:0]);
         #1 chk("analog", ana, !s[2]);
         chk("mixed", {mix, mon}, (s == 4) ? 16'h0003 : 16'h0000);
         chk("offset", offs, (s == 4) ? 16'h1234 : 16'h0000);
      end
      wr(ADDR_LOOP_ONE_SRC, {13'h0000, SRC_DIGITAL});
      wr(ADDR_LOOP_TWO_SRC, 16'h0005);
      wr(ADDR_FB_DIV_TWO, 16'h5A5A);
      #1 chk("loop srcs", {src1, src2}, 16'h0025);
      chk("fb div two", fb2, 16'h5A5A);
      rdreg(ADDR_MODE_STATUS, rd);
      chk("status mixed", rd, 16'h0007);
      chk("fb div", fb1, 16'hABCD);
      wr(ADDR_CFG_ONE, 16'h0001);
      #1 chk("one enable", {mix, mon, ib_en, dl_en}, 16'h0002);
      wr(ADDR_CFG_ONE, 16'h0002);
      #1 chk("ib off", {mix, mon, ib_en, dl_en}, 16'h0001);
      wr(ADDR_UNMAPPED, 16'hFFFF);
      rdreg(ADDR_UNMAPPED, rd);
      chk("unmapped", rd, 16'h0000);
   endtask : t_modes

   task automatic t_osc_source(logic en);
      do_reset();
      wr(ADDR_CFG_TWO, {13'h0000, en, 2'h0});
      wr(ADDR_CFG_THREE, 16'h0001);
      #1 chk("osc en", oen, en);
      base = mck - osc_count;
      osc_run <= 1'b1;
      repeat (40) @(posedge clock);
      osc_run <= 1'b0;
      repeat (4) @(posedge clock);
      #1 chk("osc ticks", mck - base, en ? osc_count : 16'h0000);
   endtask : t_osc_source

   task automatic t_divider(logic [1:0] code);
      do_reset();
      wr(ADDR_CFG_TWO, {14'h0000, code});
      wr(ADDR_CFG_THREE, 16'h0000);
      base = mck;
      loop_run <= 1'b1;
      repeat (60) @(posedge clock);
      loop_run <= 1'b0;
      repeat (5) @(posedge clock);
      #1 chk("div ticks", mck - base, (code == 2'h0) ? 16'h0000 :
         (code == 2'h3) ? loop_count / 3 : loop_count / 2);
   endtask : t_divider

   task automatic t_pins();
      for (int p = 0; p < 3; p++) begin
         wr(ADDR_CFG_TWO, {11'h000, p == 0, p < 2, 3'h0});
         #1 chk("crystal pins", {crystal_in_pin, crystal_out_pin}, {14'h0000, p < 2, p == 0});
      end
      wr(ADDR_BANK_ROUTE, 16'h000F);
      #1 chk("banks", bank, 4'hF);
   endtask : t_pins

   task automatic t_fail_irq();
      do_reset();
      ref_period <= 8'h00;
      wr(ADDR_INT_MASK, 16'h0001);
      repeat (MON_WINDOW_CYC + 10) @(posedge clock);
      #1 chk("fail set", {fail, irq}, 16'h0003);
      wr(ADDR_INT_MASK, 16'h0000);
      #1 chk("masked", irq, 1'b0);
      ref_period <= 8'h0A;
      wr(ADDR_INT_STATUS, 16'h0003);
      repeat (MON_WINDOW_CYC + 10) @(posedge clock);
      rdreg(ADDR_INT_STATUS, rd);
      chk("fail clear", rd, 16'h0000);
      wr(ADDR_CFG_ONE, 16'h0003);
      wr(ADDR_LOOP_ONE_SRC, {13'h0000, SRC_DIGITAL});
      repeat (2) @(posedge clock);
      rdreg(ADDR_INT_STATUS, rd);
      chk("mode event", rd, 16'h0002);
   endtask : t_fail_irq

   initial begin
      do_reset();
      t_reset_values();
      t_modes();
      t_pins();
      t_osc_source(1'b0);
      t_osc_source(1'b1);
      for (int c = 0; c < 4; c++) t_divider(c[1:0]);
      t_fail_irq();
      print_verdict();
   end
endmodule : mcc_top_bench
